// [rtl/plbd_core.sv]
// Loopback points, PRBS self test, reflectometry capture and energy detect.
// Assumes MAC and media byte streams share the core clock; management
// accesses arrive as one-cycle read and write strobes.
//
// Overview of operation
// - MAC loopback returns data; option also drives media.
// - Coding-sublayer loopback turns data without processing.
// - Digital loopback uses full digital path, skips analog.
// - External loopback at 10/100; analog loopback at gigabit.
// - Reverse loopback returns partner data, ignores MAC.
// - Reverse loopback option also shows data to MAC.
// - Generator sends 15-bit PRBS as packets with gaps.
// - Checker compares received bytes with local LFSR.
// - Error byte count readable at 0x0072.
// - Status shows lock, sync lost, generator busy.
// - Received byte count readable at 0x0071.
// - Continuous mode makes full counters wrap to zero.
// - Control bit 13 picks 64 or 1518 byte packets.
// - Self test runs over digital, analog or external loop.
// - Reflectometry keeps only first five reflections.
// - Cross fault keeps first location plus four reflections.
// - Reflectometry allowed after link drop; results retained.
// - Energy detect uses thresholds, hysteresis, listen periods.
// - Fast link detect modes configured at 0x001E.
// - MAC loopback in basic control; others in self-test control.
module plbd_core
    import plbd_pkg::*;
#(
    parameter int TDR_POS_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Management register port
    input wire logic [15:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_write,
    input wire logic mgmt_read,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_ack,
    // MAC side
    input wire logic [7:0] mac_tx_data,
    input wire logic mac_tx_valid,
    output logic [7:0] mac_rx_data,
    output logic mac_rx_valid,
    // Media side
    output logic [7:0] media_tx_data,
    output logic media_tx_valid,
    input wire logic [7:0] media_rx_data,
    input wire logic media_rx_valid,
    // Core status and controls
    input wire logic [1:0] link_speed,
    input wire logic link_up,
    output logic analog_loop_en,
    output logic link_drop,
    output logic [15:0] fast_link_mode,
    output logic [15:0] loopback_trim,
    // Reflectometry engine
    output logic tdr_run,
    input wire logic tdr_refl_valid,
    input wire logic [TDR_POS_W-1:0] tdr_refl_pos,
    input wire logic tdr_cross_valid,
    input wire logic [TDR_POS_W-1:0] tdr_cross_pos,
    // Energy detector
    input wire logic [7:0] energy_level,
    output logic energy_detect
);
    // Byte-wide PRBS step, x^15 + x^14 + 1; low byte holds the new bits
    function automatic logic [14:0] prbs_step(input logic [14:0] s);
        logic [14:0] t;
        t = s;
        for (int i = 0; i < 8; i++) begin
            t = {t[13:0], t[14] ^ t[13]};
        end
        return t;
    endfunction : prbs_step

    // Counter step: saturate, or wrap in continuous mode
    function automatic logic [15:0] cnt_step(input logic [15:0] v, input logic cont);
        if (v == 16'hffff) begin
            return cont ? 16'h0000 : 16'hffff;
        end
        return v + 16'h0001;
    endfunction : cnt_step

    logic [15:0] basic_control;
    logic [15:0] link_config_one;
    logic [15:0] self_test_control;
    logic [15:0] fast_link_config;
    logic [15:0] loopback_config;
    logic [15:0] received_byte_count;
    logic [15:0] error_byte_count;
    logic [15:0] energy_thresh;
    logic [15:0] energy_listen;
    logic sync_lost;
    logic chk_locked;
    logic [4:0] good_run;
    logic [14:0] gen_state;
    logic [14:0] chk_state;
    logic [10:0] gen_count;
    logic gen_in_gap;
    logic [7:0] tx_pcs_data;
    logic tx_pcs_valid;
    logic [7:0] tx_dsp_data;
    logic tx_dsp_valid;
    logic [7:0] rx_dsp_data;
    logic rx_dsp_valid;
    logic [7:0] rx_pcs_data;
    logic rx_pcs_valid;
    logic [TDR_POS_W-1:0] tdr_refl [TDR_SLOTS];
    logic [2:0] tdr_count;
    logic [TDR_POS_W-1:0] tdr_cross;
    logic tdr_cross_seen;
    logic [15:0] listen_count;

    // Loopback point decode; MAC loopback wins so only one point is live
    wire mii_loop = basic_control[BC_MII_LOOP_BIT];
    wire plbd_loop_e loop_sel = mii_loop ? LB_NONE : plbd_loop_e'(self_test_control[2:0]);
    wire pcs_loop = (loop_sel == LB_PCS);
    wire dig_loop = (loop_sel == LB_DIGITAL);
    wire rev_loop = (loop_sel == LB_REVERSE);
    // External wiring cannot carry gigabit signalling, so fold it to analog
    wire ana_loop = (loop_sel == LB_ANALOG) || (loop_sel == LB_EXTERNAL && link_speed == SPEED_GIG);
    wire gen_en = self_test_control[STC_GEN_EN_BIT];
    wire chk_en = self_test_control[STC_CHK_EN_BIT];
    wire cont_mode = self_test_control[STC_CONT_BIT];
    wire [10:0] pkt_len = self_test_control[STC_LONG_PKT_BIT] ? PKT_LEN_LONG : PKT_LEN_SHORT;

    // Generator output and transmit source
    wire [14:0] gen_next = prbs_step(gen_state);
    wire gen_byte = gen_en && !gen_in_gap;
    wire [7:0] src_data = gen_en ? gen_next[7:0] : mac_tx_data;
    wire src_valid = gen_en ? gen_byte : mac_tx_valid;

    // Receive input: digital loop turns just before the analog front end
    wire [7:0] rx_in_data = dig_loop ? tx_dsp_data : media_rx_data;
    wire rx_in_valid = dig_loop ? tx_dsp_valid : media_rx_valid;
    // Coding-sublayer loop bypasses both signal processing stages
    wire [7:0] rx_pcs_in_data = pcs_loop ? tx_pcs_data : rx_dsp_data;
    wire rx_pcs_in_valid = pcs_loop ? tx_pcs_valid : rx_dsp_valid;

    // Checker view of received bytes
    wire [14:0] chk_expect = prbs_step(chk_state);
    wire chk_byte = chk_en && rx_pcs_valid;
    wire chk_match = (rx_pcs_data == chk_expect[7:0]);
    wire chk_err = chk_byte && chk_locked && !chk_match;

    // Management decode
    wire wr_basic = mgmt_write && mgmt_addr == ADDR_BASIC_CONTROL;
    wire wr_stc = mgmt_write && mgmt_addr == ADDR_SELF_TEST_CONTROL;
    wire wr_tdr = mgmt_write && mgmt_addr == ADDR_TDR_CONTROL;
    wire tdr_allowed = !link_up || link_config_one[LINK_CONFIG_ONE_LINK_DROP_BIT];
    wire tdr_start = wr_tdr && mgmt_wdata[TDR_START_BIT] && tdr_allowed;
    wire [2:0] tdr_limit = tdr_cross_seen ? TDR_SLOTS_CROSS : 3'(TDR_SLOTS);
    wire tdr_take = tdr_refl_valid && tdr_count < tdr_limit;
    wire [15:0] status_word = (16'(chk_locked) << STS_LOCK_BIT) | (16'(sync_lost) << STS_SYNC_LOST_BIT)
        | (16'(gen_en) << STS_GEN_BUSY_BIT);
    wire [15:0] tdr_index = mgmt_addr - ADDR_TDR_RESULT0;
    wire tdr_slot_hit = mgmt_addr >= ADDR_TDR_RESULT0 && tdr_index < 16'(TDR_SLOTS);
    wire [15:0] read_word =
        (mgmt_addr == ADDR_BASIC_CONTROL) ? basic_control :
        (mgmt_addr == ADDR_LINK_CONFIG_ONE) ? link_config_one :
        (mgmt_addr == ADDR_SELF_TEST_CONTROL) ? self_test_control :
        (mgmt_addr == ADDR_SELF_TEST_STATUS) ? status_word :
        (mgmt_addr == ADDR_FAST_LINK_CONFIG) ? fast_link_config :
        (mgmt_addr == ADDR_RECEIVED_BYTE_COUNT) ? received_byte_count :
        (mgmt_addr == ADDR_ERROR_BYTE_COUNT) ? error_byte_count :
        tdr_slot_hit ? 16'(tdr_refl[tdr_index[2:0]]) :
        (mgmt_addr == ADDR_TDR_CROSS) ? 16'(tdr_cross) :
        (mgmt_addr == ADDR_TDR_STATUS) ? {12'h000, tdr_cross_seen, tdr_count} :
        (mgmt_addr == ADDR_ENERGY_THRESH) ? energy_thresh :
        (mgmt_addr == ADDR_ENERGY_LISTEN) ? energy_listen :
        (mgmt_addr == ADDR_LOOPBACK_CONFIG) ? loopback_config : 16'h0000;

    // Plain configuration outputs
    assign analog_loop_en = ana_loop;
    assign link_drop = link_config_one[LINK_CONFIG_ONE_LINK_DROP_BIT];
    assign fast_link_mode = fast_link_config;
    assign loopback_trim = loopback_config;
    assign tdr_run = tdr_start;

    // Register writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            basic_control <= RST_REG16;
            link_config_one <= RST_REG16;
            self_test_control <= RST_REG16;
            fast_link_config <= RST_REG16;
            loopback_config <= RST_REG16;
            energy_thresh <= {RST_ENERGY_HI, RST_ENERGY_LO};
            energy_listen <= RST_ENERGY_LISTEN;
        end else if (mgmt_write) begin
            if (wr_basic) basic_control <= mgmt_wdata;
            if (mgmt_addr == ADDR_LINK_CONFIG_ONE) link_config_one <= mgmt_wdata;
            if (wr_stc) self_test_control <= mgmt_wdata;
            if (mgmt_addr == ADDR_FAST_LINK_CONFIG) fast_link_config <= mgmt_wdata;
            if (mgmt_addr == ADDR_LOOPBACK_CONFIG) loopback_config <= mgmt_wdata;
            if (mgmt_addr == ADDR_ENERGY_THRESH) energy_thresh <= mgmt_wdata;
            if (mgmt_addr == ADDR_ENERGY_LISTEN) energy_listen <= mgmt_wdata;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mgmt_rdata <= 16'h0000;
            mgmt_ack <= 1'b0;
        end else begin
            mgmt_ack <= mgmt_read || mgmt_write;
            mgmt_rdata <= mgmt_read ? read_word : mgmt_rdata;
        end
    end

    // Packet generator: bytes of a running sequence, then an idle gap
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gen_state <= PRBS_SEED;
            gen_count <= 11'h000;
            gen_in_gap <= 1'b0;
        end else if (!gen_en) begin
            gen_count <= 11'h000;
            gen_in_gap <= 1'b0;
        end else if (!gen_in_gap) begin
            gen_state <= gen_next;
            gen_count <= (gen_count == pkt_len - 11'h001) ? 11'h000 : gen_count + 11'h001;
            gen_in_gap <= (gen_count == pkt_len - 11'h001);
        end else begin
            gen_count <= (gen_count == IPG_LEN - 11'h001) ? 11'h000 : gen_count + 11'h001;
            gen_in_gap <= (gen_count != IPG_LEN - 11'h001);
        end
    end

    // Datapath stages; the generator replaces MAC data while it runs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_pcs_data <= 8'h00;
            tx_pcs_valid <= 1'b0;
            tx_dsp_data <= 8'h00;
            tx_dsp_valid <= 1'b0;
            rx_dsp_data <= 8'h00;
            rx_dsp_valid <= 1'b0;
            rx_pcs_data <= 8'h00;
            rx_pcs_valid <= 1'b0;
        end else begin
            tx_pcs_data <= src_data;
            tx_pcs_valid <= src_valid && !rev_loop;
            tx_dsp_data <= tx_pcs_data;
            tx_dsp_valid <= tx_pcs_valid;
            rx_dsp_data <= rx_in_data;
            rx_dsp_valid <= rx_in_valid;
            rx_pcs_data <= rx_pcs_in_data;
            rx_pcs_valid <= rx_pcs_in_valid;
        end
    end

    // Media and MAC outputs per loopback point
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            media_tx_data <= 8'h00;
            media_tx_valid <= 1'b0;
            mac_rx_data <= 8'h00;
            mac_rx_valid <= 1'b0;
        end else if (mii_loop) begin
            mac_rx_data <= mac_tx_data;
            mac_rx_valid <= mac_tx_valid;
            media_tx_data <= tx_dsp_data;
            media_tx_valid <= tx_dsp_valid && self_test_control[STC_MII_TO_MEDIA_BIT];
        end else if (rev_loop) begin
            media_tx_data <= rx_pcs_data;
            media_tx_valid <= rx_pcs_valid;
            mac_rx_data <= rx_pcs_data;
            mac_rx_valid <= rx_pcs_valid && self_test_control[STC_REV_TO_MAC_BIT];
        end else begin
            // Coding-sublayer and digital loops keep the line quiet to avoid upsetting the partner
            media_tx_data <= tx_dsp_data;
            media_tx_valid <= tx_dsp_valid && !pcs_loop && !dig_loop;
            mac_rx_data <= rx_pcs_data;
            mac_rx_valid <= rx_pcs_valid;
        end
    end

    // Checker: self-synchronising on received bytes, lock after a good run
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chk_state <= PRBS_SEED;
            chk_locked <= 1'b0;
            good_run <= 5'h00;
            sync_lost <= 1'b0;
        end else if (!chk_en) begin
            chk_locked <= 1'b0;
            good_run <= 5'h00;
            sync_lost <= 1'b0;
        end else if (chk_byte) begin
            chk_state <= {chk_state[6:0], rx_pcs_data};
            good_run <= chk_match ? ((good_run == LOCK_GOOD_BYTES) ? good_run : good_run + 5'h01) : 5'h00;
            chk_locked <= chk_match && (chk_locked || good_run == LOCK_GOOD_BYTES - 5'h01);
            sync_lost <= sync_lost || chk_err;
        end
    end

    // Byte counters; restarted by a write that enables the checker
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            received_byte_count <= 16'h0000;
            error_byte_count <= 16'h0000;
        end else if (wr_stc && mgmt_wdata[STC_CHK_EN_BIT] && !chk_en) begin
            received_byte_count <= 16'h0000;
            error_byte_count <= 16'h0000;
        end else if (chk_byte) begin
            received_byte_count <= cnt_step(received_byte_count, cont_mode);
            if (chk_err) error_byte_count <= cnt_step(error_byte_count, cont_mode);
        end
    end

    // Reflectometry capture; results stay until the next start
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tdr_count <= 3'h0;
            tdr_cross <= '0;
            tdr_cross_seen <= 1'b0;
            for (int i = 0; i < TDR_SLOTS; i++) tdr_refl[i] <= '0;
        end else if (tdr_start) begin
            tdr_count <= 3'h0;
            tdr_cross_seen <= 1'b0;
        end else begin
            if (tdr_cross_valid && !tdr_cross_seen) begin
                tdr_cross <= tdr_cross_pos;
                tdr_cross_seen <= 1'b1;
            end
            if (tdr_take) begin
                tdr_refl[tdr_count] <= tdr_refl_pos;
                tdr_count <= tdr_count + 3'h1;
            end
        end
    end

    // Energy detect: hysteresis band, level must persist a listen period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            energy_detect <= 1'b0;
            listen_count <= 16'h0000;
        end else if (energy_detect ? energy_level < energy_thresh[7:0] : energy_level > energy_thresh[15:8]) begin
            listen_count <= listen_count + 16'h0001;
            if (listen_count + 16'h0001 >= energy_listen) begin
                energy_detect <= !energy_detect;
                listen_count <= 16'h0000;
            end
        end else begin
            listen_count <= 16'h0000;
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_mac_byte;
        mac_tx_valid && mii_loop;
    endsequence
    property p_mii_return;
        s_mac_byte |=> mac_rx_valid && mac_rx_data == $past(mac_tx_data);
    endproperty
    a_mii_return: assert property (p_mii_return) else $error("mac loop data not returned");
    property p_pcs_turn;
        pcs_loop && !mii_loop && src_valid && !gen_en ##1 pcs_loop |=> rx_pcs_valid && rx_pcs_data == $past(tx_pcs_data);
    endproperty
    a_pcs_turn: assert property (p_pcs_turn) else $error("pcs loop byte mismatch");
    property p_dig_quiet;
        dig_loop ##1 dig_loop |=> !media_tx_valid;
    endproperty
    a_dig_quiet: assert property (p_dig_quiet) else $error("media driven in digital loop");
    property p_rev_ignores_mac;
        rev_loop |=> !tx_pcs_valid;
    endproperty
    a_rev_ignores_mac: assert property (p_rev_ignores_mac) else $error("mac data used in reverse loop");
    property p_rev_to_mac;
        rev_loop && !self_test_control[STC_REV_TO_MAC_BIT] |=> !mac_rx_valid;
    endproperty
    a_rev_to_mac: assert property (p_rev_to_mac) else $error("mac output without option");
    property p_gap_after_packet;
        gen_en && !gen_in_gap && gen_count == pkt_len - 11'h001 ##1 gen_en |-> gen_in_gap;
    endproperty
    a_gap_after_packet: assert property (p_gap_after_packet) else $error("no gap after packet");
    property p_err_count;
        chk_err && error_byte_count != 16'hffff && !wr_stc |=> error_byte_count == $past(error_byte_count) + 16'h0001;
    endproperty
    a_err_count: assert property (p_err_count) else $error("error byte not counted");
    property p_wrap;
        chk_byte && cont_mode && received_byte_count == 16'hffff && !wr_stc |=> received_byte_count == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");
    property p_tdr_cap;
        tdr_count <= tdr_limit;
    endproperty
    a_tdr_cap: assert property (p_tdr_cap) else $error("too many reflections kept");
    property p_ext_gig;
        loop_sel == LB_EXTERNAL && link_speed == SPEED_GIG |-> analog_loop_en;
    endproperty
    a_ext_gig: assert property (p_ext_gig) else $error("gigabit external loop not analog");
endmodule : plbd_core

// [rtl/plbd_pkg.sv]
// Constants shared by the loopback, self-test and diagnostic block.
// Assumes a 16-bit management register space with word addresses.
package plbd_pkg;
    // Register addresses
    localparam logic [15:0] ADDR_BASIC_CONTROL = 16'h0000;
    localparam logic [15:0] ADDR_LINK_CONFIG_ONE = 16'h0009;
    localparam logic [15:0] ADDR_SELF_TEST_CONTROL = 16'h0016;
    localparam logic [15:0] ADDR_SELF_TEST_STATUS = 16'h0017;
    localparam logic [15:0] ADDR_FAST_LINK_CONFIG = 16'h001e;
    localparam logic [15:0] ADDR_RECEIVED_BYTE_COUNT = 16'h0071;
    localparam logic [15:0] ADDR_ERROR_BYTE_COUNT = 16'h0072;
    localparam logic [15:0] ADDR_TDR_CONTROL = 16'h00a0;
    localparam logic [15:0] ADDR_TDR_RESULT0 = 16'h00a1;
    localparam logic [15:0] ADDR_TDR_CROSS = 16'h00a6;
    localparam logic [15:0] ADDR_TDR_STATUS = 16'h00a7;
    localparam logic [15:0] ADDR_ENERGY_THRESH = 16'h00a8;
    localparam logic [15:0] ADDR_ENERGY_LISTEN = 16'h00a9;
    localparam logic [15:0] ADDR_LOOPBACK_CONFIG = 16'h00fe;

    // Field positions
    localparam int BC_MII_LOOP_BIT = 14;
    localparam int LINK_CONFIG_ONE_LINK_DROP_BIT = 7;
    localparam int STC_GEN_EN_BIT = 15;
    localparam int STC_CONT_BIT = 14;
    localparam int STC_LONG_PKT_BIT = 13;
    localparam int STC_CHK_EN_BIT = 12;
    localparam int STC_MII_TO_MEDIA_BIT = 5;
    localparam int STC_REV_TO_MAC_BIT = 4;
    localparam int STS_LOCK_BIT = 11;
    localparam int STS_SYNC_LOST_BIT = 10;
    localparam int STS_GEN_BUSY_BIT = 9;
    localparam int TDR_START_BIT = 0;

    // Reset values
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [7:0] RST_ENERGY_HI = 8'h40;
    localparam logic [7:0] RST_ENERGY_LO = 8'h20;
    localparam logic [15:0] RST_ENERGY_LISTEN = 16'h0010;

    // Self-test packet shape in bytes, checker lock run and PRBS seed
    localparam logic [10:0] PKT_LEN_SHORT = 11'h040;
    localparam logic [10:0] PKT_LEN_LONG = 11'h5ee;
    localparam logic [10:0] IPG_LEN = 11'h00c;
    localparam logic [4:0] LOCK_GOOD_BYTES = 5'h10;
    localparam logic [14:0] PRBS_SEED = 15'h7fff;

    // Reflectometry storage
    localparam int TDR_SLOTS = 5;
    localparam logic [2:0] TDR_SLOTS_CROSS = 3'h4;

    // Loopback point select, self_test_control[2:0]
    typedef enum logic [2:0] {
        LB_NONE = 3'b000,
        LB_PCS = 3'b001,
        LB_DIGITAL = 3'b010,
        LB_ANALOG = 3'b011,
        LB_EXTERNAL = 3'b100,
        LB_REVERSE = 3'b101
    } plbd_loop_e;

    // Link speed code
    localparam logic [1:0] SPEED_GIG = 2'h2;
endpackage : plbd_pkg

// [tb/plbd_link_partner.sv]
// Link partner on the media side: a cable loop fixture or a byte injector.
// Assumes media bytes share the core clock of the block.
module plbd_link_partner (
    // Clock
    input wire logic clock,
    // Bench control and injected bytes
    input wire logic echo_en,
    input wire logic [7:0] inj_data,
    input wire logic inj_valid,
    // Media lines
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // Idle data inverts every cycle, so it alternates between the inverse of the last byte and the byte itself
    // Echo keeps a fixed straight pair mapping, as with crossover turned off
    always @(posedge clock) begin
        rx_valid <= echo_en ? tx_valid : inj_valid;
        if (echo_en ? tx_valid : inj_valid) begin
            rx_data <= echo_en ? tx_data : inj_data;
        end else begin
            rx_data <= ~rx_data;
        end
    end
endmodule : plbd_link_partner

// [tb/testbench.sv]
// Self-checking bench: register accesses, loopback points and self test.
// Assumes the partner echoes media bytes when acting as a cable fixture.
module testbench;
    import plbd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, reset_n = 1'b0, mgmt_write = 1'b0, mgmt_read = 1'b0, mgmt_ack, link_up = 1'b0;
    logic [15:0] mgmt_addr = 16'h0000, mgmt_wdata = 16'h0000, mgmt_rdata, fast_link_mode, loopback_trim, d;
    logic [7:0] mac_tx_data = 8'h00, mac_rx_data, media_tx_data, media_rx_data, inj_data = 8'h00;
    logic mac_tx_valid = 1'b0, mac_rx_valid, media_tx_valid, media_rx_valid, inj_valid = 1'b0, echo_en = 1'b0;
    logic analog_loop_en, link_drop, tdr_run, energy_detect;
    logic [1:0] link_speed = 2'h1;
    logic [7:0] energy_level = 8'h00;
    logic tdr_refl_valid = 1'b0;
    logic [15:0] tdr_refl_pos = 16'h0000;
    int n_errors = 0, comparisons = 0, cycles = 0;
    initial forever #12.5 clock = ~clock;
    plbd_core plbd_core_i (.clock(clock), .reset_n(reset_n), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
        .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack),
        .mac_tx_data(mac_tx_data), .mac_tx_valid(mac_tx_valid), .mac_rx_data(mac_rx_data),
        .mac_rx_valid(mac_rx_valid), .media_tx_data(media_tx_data), .media_tx_valid(media_tx_valid),
        .media_rx_data(media_rx_data), .media_rx_valid(media_rx_valid), .link_speed(link_speed),
        .link_up(link_up), .analog_loop_en(analog_loop_en), .link_drop(link_drop),
        .fast_link_mode(fast_link_mode), .loopback_trim(loopback_trim), .tdr_run(tdr_run),
        .tdr_refl_valid(tdr_refl_valid), .tdr_refl_pos(tdr_refl_pos), .tdr_cross_valid(1'b0),
        .tdr_cross_pos(16'h0000), .energy_level(energy_level), .energy_detect(energy_detect));
    plbd_link_partner plbd_link_partner_i (.clock(clock), .echo_en(echo_en), .inj_data(inj_data),
        .inj_valid(inj_valid), .tx_data(media_tx_data), .tx_valid(media_tx_valid),
        .rx_data(media_rx_data), .rx_valid(media_rx_valid));
    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // One strobe, then the ack is looked at in its single cycle
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] w, output logic [15:0] r);
        @(posedge clock);
        mgmt_addr <= a;
        mgmt_wdata <= w;
        mgmt_write <= wr;
        mgmt_read <= ~wr;
        @(posedge clock);
        mgmt_write <= 1'b0;
        mgmt_read <= 1'b0;
        #1;
        check("ack", 16'h0001, {15'h0000, mgmt_ack});
        r = mgmt_rdata;
    endtask : access
    // Bounded wait for a media byte; MAC side must stay quiet meanwhile
    task automatic wait_media(input logic [7:0] exp);
        for (int i = 0; i < 10 && media_tx_valid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
            if (mac_rx_valid !== 1'b0) check("mac_rx_valid", 16'h0000, {15'h0000, mac_rx_valid});
        end
        check("media_tx", {8'h01, exp}, {7'h00, media_tx_valid, media_tx_data});
    endtask : wait_media
    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        access(1'b0, ADDR_LOOPBACK_CONFIG, 16'h0000, d);
        check("loopback_config reset", RST_REG16, d);
        access(1'b1, ADDR_LOOPBACK_CONFIG, 16'he720, d);
        access(1'b0, ADDR_LOOPBACK_CONFIG, 16'h0000, d);
        check("loopback_config", 16'he720, d);
        check("loopback_trim", 16'he720, loopback_trim);
        access(1'b0, 16'h0055, 16'h0000, d);
        check("unmapped", 16'h0000, d);
        access(1'b1, ADDR_FAST_LINK_CONFIG, 16'h1234, d);
        check("fast_link_mode", 16'h1234, fast_link_mode);
        access(1'b1, ADDR_LINK_CONFIG_ONE, 16'h0080, d);
        check("link_drop", 16'h0001, {15'h0000, link_drop});
        // Shallowest loop returns the byte on the next cycle
        access(1'b1, ADDR_BASIC_CONTROL, 16'h4000, d);
        @(posedge clock);
        mac_tx_data <= 8'h5a;
        mac_tx_valid <= 1'b1;
        @(posedge clock);
        mac_tx_valid <= 1'b0;
        #1;
        check("mac_rx", 16'h015a, {7'h00, mac_rx_valid, mac_rx_data});
        access(1'b1, ADDR_BASIC_CONTROL, 16'h0000, d);
        // Reverse loop: partner byte returns, a clashing MAC byte is dropped
        access(1'b1, ADDR_SELF_TEST_CONTROL, 16'h0005, d);
        @(posedge clock);
        inj_data <= 8'h3c;
        inj_valid <= 1'b1;
        mac_tx_data <= 8'ha5;
        mac_tx_valid <= 1'b1;
        @(posedge clock);
        inj_valid <= 1'b0;
        mac_tx_valid <= 1'b0;
        wait_media(8'h3c);
        // Self test over a cable fixture at 100 Mb/s
        echo_en <= 1'b1;
        access(1'b1, ADDR_SELF_TEST_CONTROL, 16'h9004, d);
        repeat (300) @(posedge clock);
        access(1'b0, ADDR_SELF_TEST_STATUS, 16'h0000, d);
        check("lock", 16'h0001, {15'h0000, d[STS_LOCK_BIT]});
        check("sync_lost", 16'h0000, {15'h0000, d[STS_SYNC_LOST_BIT]});
        access(1'b0, ADDR_ERROR_BYTE_COUNT, 16'h0000, d);
        check("error_byte_count", 16'h0000, d);
        access(1'b0, ADDR_RECEIVED_BYTE_COUNT, 16'h0000, d);
        check("received_nonzero", 16'h0001, {15'h0000, d > 16'h0000});
        // External selection at gigabit must fall back to the analog loop
        link_speed <= SPEED_GIG;
        access(1'b1, ADDR_SELF_TEST_CONTROL, 16'h0004, d);
        check("analog_loop_en", 16'h0001, {15'h0000, analog_loop_en});
        // Reflectometry with the link down: six echoes, only five kept
        access(1'b1, ADDR_TDR_CONTROL, 16'h0001, d);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock);
            tdr_refl_valid <= 1'b1;
            tdr_refl_pos <= tdr_refl_pos + 16'h0001;
            @(posedge clock);
            tdr_refl_valid <= 1'b0;
        end
        access(1'b0, ADDR_TDR_STATUS, 16'h0000, d);
        check("tdr_status", 16'h0005, d);
        access(1'b0, ADDR_TDR_RESULT0, 16'h0000, d);
        check("tdr_first", 16'h0001, d);
        access(1'b0, ADDR_TDR_RESULT0 + 16'h0004, 16'h0000, d);
        check("tdr_fifth", 16'h0005, d);
        // Energy above the high threshold for a listen period sets detect
        energy_level <= 8'h50;
        repeat (20) @(posedge clock);
        #1;
        check("energy_on", 16'h0001, {15'h0000, energy_detect});
        // Inside the hysteresis band the indication must hold
        energy_level <= 8'h30;
        repeat (20) @(posedge clock);
        #1;
        check("energy_hold", 16'h0001, {15'h0000, energy_detect});
        wrap_up();
    end
endmodule : testbench
